// [hw/mss_sequencer.sv]
// Local design decisions: the plain strobed port and the register addresses.
`include "mss_defs.svh"
// Summary of operation
// - Step interval 1..32768, reset 1, added to or subtracted from master.
// - Master is fixed-digit decimal, wraps both ways, never negative.
// - Match in increment mode advances master by step; mismatch holds it otherwise.
// - Match substitution enabled with matching active sends match text; default off.
// - Match text up to 64 characters, reset to MATCH.
// - Mismatch substitution enabled with matching active sends mismatch text; default off.
// - Mismatch text up to 64 characters, reset to MISMATCH.
// - Capture input acts only when matching and capture feature enabled.
// - After a load request, next good read loads master slots from slot 1.
// - Load status gives next slot to load; 0 means idle.
// - Host or input request sets status to slot 1 unless a slot loads in the same cycle; cleared after last slot.
// - Direction 0 counts up (default), 1 counts down.
// - Sequence on no-read (default on) steps master on a no-read.
// - Mismatch steps only after a match unless sequence on mismatch set.
module mss_sequencer
	import mss_pkg::*;
#(
	parameter int MAX_DIGITS = 8,
	parameter int NUM_SLOTS = `MSS_NUM_SLOTS,
	parameter int HOLD_CYC = `MSS_HOLD_CYC
) (
	// Clock and reset
	input wire logic SYS_CLK,
	input wire logic RESET,
	// Register port
	input wire logic [11:0] ADDR,
	input wire logic [31:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [31:0] RDATA,
	// Capture input
	input wire logic NEW_MASTER_IN,
	// Decoder results
	input wire logic DEC_VALID,
	input wire logic DEC_GOOD,
	input wire logic DEC_NUMERIC,
	input wire logic [3:0] DEC_LEN,
	input wire logic [4*MAX_DIGITS-1:0] DEC_DIGITS,
	// Results
	output logic RES_VALID,
	output logic RES_MATCH,
	output mss_pkg::mss_out_t RES_SUBST,
	output logic [4*MAX_DIGITS-1:0] RES_MASTER,
	output logic [7:0] LOAD_STATUS
);
	import mss_pkg::*;
	localparam int W = 4 * MAX_DIGITS;
	localparam int CW = $clog2(HOLD_CYC + 1);
	localparam int TD = `MSS_TXT_DEPTH;

	function automatic logic [7:0] init_char(logic [63:0] s, int len, int i);
		init_char = (i < len) ? 8'(s >> (8 * (len - 1 - i))) : 8'h00;
	endfunction

	////////////////////////////////////////////////////////////////////////
	logic [`MSS_CTRL_W-1:0] ctrl_reg, ctrl_next;
	logic [15:0] step_reg, step_next;
	logic [W-1:0] master_reg, master_next;
	logic [3:0] mlen_reg, mlen_next;
	logic [7:0] status_reg, status_next;
	logic prev_match_reg, prev_match_next;
	logic [7:0] mtxt_reg [TD], mtxt_next [TD];
	logic [7:0] xtxt_reg [TD], xtxt_next [TD];
	logic [6:0] mtlen_reg, mtlen_next, xtlen_reg, xtlen_next;
	logic [31:0] rdata_reg, rdata_next;
	logic res_valid_reg, res_valid_next, res_match_reg, res_match_next;
	mss_out_t res_subst_reg, res_subst_next;
	logic [W-1:0] res_master_reg, res_master_next;
	mss_db_state_t db_reg, db_next;
	logic [CW-1:0] cnt_reg, cnt_next;

	logic match_en, dir_down, seq_noread, seq_mm, msub_en, xsub_en, cap_en;
	assign match_en = ctrl_reg[`MSS_BIT_MATCH_EN];
	assign dir_down = ctrl_reg[`MSS_BIT_DIR];
	assign seq_noread = ctrl_reg[`MSS_BIT_SEQ_NOREAD];
	assign seq_mm = ctrl_reg[`MSS_BIT_SEQ_MISMATCH];
	assign msub_en = ctrl_reg[`MSS_BIT_MSUB_EN];
	assign xsub_en = ctrl_reg[`MSS_BIT_XSUB_EN];
	assign cap_en = ctrl_reg[`MSS_BIT_CAP_EN];

	////////////////////////////////////////////////////////////////////////
	// Step arithmetic on the active digits only
	logic [W-1:0] dmask, step_bcd, step_sum, raw_sum;
	logic [19:0] step5;
	for (genvar g = 0; g < MAX_DIGITS; g++) begin : g_mask
		assign dmask[4*g+:4] = (g < int'(mlen_reg)) ? 4'hf : 4'h0;
	end

	mss_bin2bcd u_bin2bcd (
		.bin(step_reg),
		.bcd(step5)
	);
	assign step_bcd = {{(W-20){1'b0}}, step5} & dmask;

	mss_bcd_addsub #(.DIGITS(MAX_DIGITS)) u_addsub (
		.a(master_reg & dmask),
		.b(step_bcd),
		.sub(dir_down),
		.y(raw_sum)
	);
	// Carry beyond the top digit is dropped, so the count rolls over
	assign step_sum = raw_sum & dmask;

	////////////////////////////////////////////////////////////////////////
	// Capture input qualifier
	logic pin_fire, pin_req;
	always_comb begin
		db_next = db_reg;
		cnt_next = cnt_reg;
		pin_fire = 1'b0;
		unique case (db_reg)
			MSS_DB_IDLE: begin
				cnt_next = '0;
				if (NEW_MASTER_IN) begin
					db_next = MSS_DB_COUNT;
				end
			end
			MSS_DB_COUNT: begin
				if (!NEW_MASTER_IN) begin
					db_next = MSS_DB_IDLE;
				end else if (cnt_reg == CW'(HOLD_CYC - 1)) begin
					db_next = MSS_DB_FIRED;
					pin_fire = 1'b1;
				end else begin
					cnt_next = cnt_reg + 1'b1;
				end
			end
			MSS_DB_FIRED: begin
				if (!NEW_MASTER_IN) begin
					db_next = MSS_DB_IDLE;
				end
			end
			default: db_next = MSS_DB_IDLE;
		endcase
	end
	assign pin_req = pin_fire & match_en & cap_en;

	////////////////////////////////////////////////////////////////////////
	// Register writes and sequencing
	logic host_req, loading, dec_match, active;
	assign host_req = WR && ADDR == `MSS_OFS_LOAD && WDATA[0];
	assign loading = status_reg != 8'h00;
	assign dec_match = DEC_GOOD && DEC_NUMERIC && DEC_LEN == mlen_reg
		&& (DEC_DIGITS & dmask) == (master_reg & dmask);
	assign active = DEC_VALID && match_en && !loading;

	always_comb begin
		ctrl_next = ctrl_reg;
		step_next = step_reg;
		master_next = master_reg;
		mlen_next = mlen_reg;
		status_next = status_reg;
		prev_match_next = prev_match_reg;
		mtxt_next = mtxt_reg;
		xtxt_next = xtxt_reg;
		mtlen_next = mtlen_reg;
		xtlen_next = xtlen_reg;
		res_valid_next = DEC_VALID;
		res_match_next = 1'b0;
		res_subst_next = MSS_OUT_DECODED;
		if (WR) begin
			if (ADDR == `MSS_OFS_CTRL) begin
				ctrl_next = WDATA[`MSS_CTRL_W-1:0];
			end
			if (ADDR == `MSS_OFS_STEP && WDATA[31:16] == 16'h0000
				&& WDATA[15:0] >= `MSS_STEP_MIN && WDATA[15:0] <= `MSS_STEP_MAX) begin
				step_next = WDATA[15:0];
			end
			if (ADDR == `MSS_OFS_MASTER) begin
				master_next = WDATA[W-1:0];
			end
			if (ADDR == `MSS_OFS_MLEN && WDATA[3:0] != 4'h0 && int'(WDATA[3:0]) <= MAX_DIGITS) begin
				mlen_next = WDATA[3:0];
			end
			if (ADDR == `MSS_OFS_MTLEN && WDATA[6:0] <= 7'(TD)) begin
				mtlen_next = WDATA[6:0];
			end
			if (ADDR == `MSS_OFS_XTLEN && WDATA[6:0] <= 7'(TD)) begin
				xtlen_next = WDATA[6:0];
			end
			if (ADDR[11:8] == `MSS_PAGE_MTXT) begin
				mtxt_next[ADDR[7:2]] = WDATA[7:0];
			end
			if (ADDR[11:8] == `MSS_PAGE_XTXT) begin
				xtxt_next[ADDR[7:2]] = WDATA[7:0];
			end
		end
		if (host_req || pin_req) begin
			status_next = 8'h01;
		end
		if (DEC_VALID && loading && DEC_GOOD && DEC_NUMERIC
			&& DEC_LEN != 4'h0 && int'(DEC_LEN) <= MAX_DIGITS) begin
			master_next = DEC_DIGITS;
			mlen_next = DEC_LEN;
			prev_match_next = 1'b0;
			status_next = (status_reg == 8'(NUM_SLOTS)) ? 8'h00 : status_reg + 8'h01;
		end else if (active) begin
			if (!DEC_GOOD) begin
				if (seq_noread) begin
					master_next = step_sum;
				end
			end else if (dec_match) begin
				master_next = step_sum;
				prev_match_next = 1'b1;
				res_match_next = 1'b1;
				res_subst_next = msub_en ? MSS_OUT_MATCH_TXT : MSS_OUT_DECODED;
			end else begin
				if (seq_mm || prev_match_reg) begin
					master_next = step_sum;
				end
				prev_match_next = 1'b0;
				res_subst_next = xsub_en ? MSS_OUT_MISMATCH_TXT : MSS_OUT_DECODED;
			end
		end
		// Mask by the new count, so a load shows all of its own digits
		for (int g = 0; g < MAX_DIGITS; g++) begin
			res_master_next[4*g+:4] = (g < int'(mlen_next)) ? master_next[4*g+:4] : 4'h0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read port, data one cycle after the strobe
	always_comb begin
		rdata_next = 32'h00000000;
		if (RD) begin
			if (ADDR == `MSS_OFS_CTRL) begin
				rdata_next = {{(32-`MSS_CTRL_W){1'b0}}, ctrl_reg};
			end else if (ADDR == `MSS_OFS_STEP) begin
				rdata_next = {16'h0000, step_reg};
			end else if (ADDR == `MSS_OFS_MASTER) begin
				rdata_next = 32'(master_reg & dmask);
			end else if (ADDR == `MSS_OFS_MLEN) begin
				rdata_next = {28'h0000000, mlen_reg};
			end else if (ADDR == `MSS_OFS_LOAD) begin
				rdata_next = {24'h000000, status_reg};
			end else if (ADDR == `MSS_OFS_MTLEN) begin
				rdata_next = {25'h0000000, mtlen_reg};
			end else if (ADDR == `MSS_OFS_XTLEN) begin
				rdata_next = {25'h0000000, xtlen_reg};
			end else if (ADDR[11:8] == `MSS_PAGE_MTXT) begin
				rdata_next = {24'h000000, mtxt_reg[ADDR[7:2]]};
			end else if (ADDR[11:8] == `MSS_PAGE_XTXT) begin
				rdata_next = {24'h000000, xtxt_reg[ADDR[7:2]]};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			ctrl_reg <= `MSS_CTRL_RST;
			step_reg <= `MSS_STEP_RST;
			master_reg <= W'(`MSS_MASTER_RST);
			mlen_reg <= `MSS_MLEN_RST;
			status_reg <= 8'h00;
			prev_match_reg <= 1'b0;
			for (int i = 0; i < TD; i++) begin
				mtxt_reg[i] <= init_char(`MSS_MTXT_INIT, `MSS_MTXT_LEN, i);
				xtxt_reg[i] <= init_char(`MSS_XTXT_INIT, `MSS_XTXT_LEN, i);
			end
			mtlen_reg <= `MSS_MTXT_LEN;
			xtlen_reg <= `MSS_XTXT_LEN;
			rdata_reg <= 32'h00000000;
			res_valid_reg <= 1'b0;
			res_match_reg <= 1'b0;
			res_subst_reg <= MSS_OUT_DECODED;
			res_master_reg <= '0;
			db_reg <= MSS_DB_IDLE;
			cnt_reg <= '0;
		end else begin
			ctrl_reg <= ctrl_next;
			step_reg <= step_next;
			master_reg <= master_next;
			mlen_reg <= mlen_next;
			status_reg <= status_next;
			prev_match_reg <= prev_match_next;
			mtxt_reg <= mtxt_next;
			xtxt_reg <= xtxt_next;
			mtlen_reg <= mtlen_next;
			xtlen_reg <= xtlen_next;
			rdata_reg <= rdata_next;
			res_valid_reg <= res_valid_next;
			res_match_reg <= res_match_next;
			res_subst_reg <= res_subst_next;
			res_master_reg <= res_master_next;
			db_reg <= db_next;
			cnt_reg <= cnt_next;
		end
	end

	assign RDATA = rdata_reg;
	assign RES_VALID = res_valid_reg;
	assign RES_MATCH = res_match_reg;
	assign RES_SUBST = res_subst_reg;
	assign RES_MASTER = res_master_reg;
	assign LOAD_STATUS = status_reg;

	////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	sequence s_match_ev;
		active && DEC_GOOD && dec_match;
	endsequence
	sequence s_mismatch_ev;
		active && DEC_GOOD && !dec_match;
	endsequence

	a_step_range: assert property (step_reg >= `MSS_STEP_MIN && step_reg <= `MSS_STEP_MAX)
		else $error("step interval out of range");
	a_digit_wrap: assert property (RES_VALID |-> (RES_MASTER & ~dmask) == '0)
		else $error("master digits beyond count");
	a_match_step: assert property (s_match_ev |=> master_reg == $past(step_sum))
		else $error("master not stepped on match");
	a_match_text: assert property (s_match_ev ##1 1 |-> RES_SUBST == ($past(msub_en)
		? MSS_OUT_MATCH_TXT : MSS_OUT_DECODED) && RES_MATCH)
		else $error("wrong output on match");
	a_mismatch_text: assert property (s_mismatch_ev |=> RES_SUBST == ($past(xsub_en)
		? MSS_OUT_MISMATCH_TXT : MSS_OUT_DECODED) && !RES_MATCH)
		else $error("wrong output on mismatch");
	a_pin_hold: assert property (pin_fire |-> $past(NEW_MASTER_IN) && db_reg == MSS_DB_COUNT)
		else $error("capture fired without hold");
	a_pin_gated: assert property (pin_fire && !(match_en && cap_en) && !host_req && !loading
		|=> LOAD_STATUS == 8'h00)
		else $error("capture acted while disabled");
	a_load_request: assert property (host_req && !DEC_VALID |=> LOAD_STATUS == 8'h01)
		else $error("load request not seen");
	a_load_clear: assert property (DEC_VALID && DEC_GOOD && DEC_NUMERIC && DEC_LEN != 4'h0
		&& int'(DEC_LEN) <= MAX_DIGITS && status_reg == 8'(NUM_SLOTS) && !host_req && !pin_req
		|=> LOAD_STATUS == 8'h00 && master_reg == $past(DEC_DIGITS))
		else $error("final slot not loaded and cleared");
	a_noread_hold: assert property (active && !DEC_GOOD && !seq_noread && !WR
		|=> $stable(master_reg))
		else $error("master moved on no-read");
	a_second_mismatch: assert property (s_mismatch_ev and (!prev_match_reg && !seq_mm && !WR)
		|=> $stable(master_reg) ##1 1)
		else $error("master moved on repeated mismatch");
endmodule // mss_sequencer

// [include/mss_defs.svh]
`ifndef MSS_DEFS_SVH
`define MSS_DEFS_SVH

// Register byte offsets
`define MSS_OFS_CTRL 12'h000
`define MSS_OFS_STEP 12'h004
`define MSS_OFS_MASTER 12'h008
`define MSS_OFS_MLEN 12'h00c
`define MSS_OFS_LOAD 12'h010
`define MSS_OFS_MTLEN 12'h014
`define MSS_OFS_XTLEN 12'h018
`define MSS_PAGE_MTXT 4'h1
`define MSS_PAGE_XTXT 4'h2

// Control fields
`define MSS_CTRL_W 7
`define MSS_BIT_MATCH_EN 0
`define MSS_BIT_DIR 1
`define MSS_BIT_SEQ_NOREAD 2
`define MSS_BIT_SEQ_MISMATCH 3
`define MSS_BIT_MSUB_EN 4
`define MSS_BIT_XSUB_EN 5
`define MSS_BIT_CAP_EN 6
`define MSS_CTRL_RST 7'h04

// Step interval
`define MSS_STEP_MIN 16'h0001
`define MSS_STEP_MAX 16'h8000
`define MSS_STEP_RST 16'h0001

// Substitution texts
`define MSS_TXT_DEPTH 64
`define MSS_MTXT_INIT 64'h0000004d41544348
`define MSS_MTXT_LEN 7'h05
`define MSS_XTXT_INIT 64'h4d49534d41544348
`define MSS_XTXT_LEN 7'h08

// Master defaults
`define MSS_MASTER_RST 32'h00000000
`define MSS_MLEN_RST 4'h3
`define MSS_NUM_SLOTS 1

// Capture input hold time
`define MSS_HOLD_MS 10
`define MSS_CLK_HZ 20000000
`define MSS_HOLD_CYC ((`MSS_HOLD_MS * `MSS_CLK_HZ + 999) / 1000)

`endif

// [include/mss_pkg.sv]
package mss_pkg;
	// Capture input qualifier, Gray along idle -> count -> fired
	typedef enum logic [1:0] {
		MSS_DB_IDLE = 2'b00,
		MSS_DB_COUNT = 2'b01,
		MSS_DB_FIRED = 2'b11
	} mss_db_state_t;

	// Which text leaves with a result
	typedef enum logic [1:0] {
		MSS_OUT_DECODED = 2'b00,
		MSS_OUT_MATCH_TXT = 2'b01,
		MSS_OUT_MISMATCH_TXT = 2'b10
	} mss_out_t;
endpackage

// [hw/mss_bin2bcd.sv]
module mss_bin2bcd (
	// Binary in
	input wire logic [15:0] bin,
	// Five BCD digits out
	output logic [19:0] bcd
);
	always_comb begin
		logic [35:0] sh;
		sh = {20'h00000, bin};
		for (int i = 0; i < 16; i++) begin
			for (int d = 0; d < 5; d++) begin
				if (sh[16 + 4 * d +: 4] > 4'h4) begin
					sh[16 + 4 * d +: 4] = sh[16 + 4 * d +: 4] + 4'h3;
				end
			end
			sh = {sh[34:0], 1'b0};
		end
		bcd = sh[35:16];
	end
endmodule // mss_bin2bcd

// [hw/mss_bcd_addsub.sv]
module mss_bcd_addsub #(
	parameter int DIGITS = 8
) (
	// Operands
	input wire logic [4*DIGITS-1:0] a,
	input wire logic [4*DIGITS-1:0] b,
	input wire logic sub,
	// Result, carry out of the top digit dropped
	output logic [4*DIGITS-1:0] y
);
	logic [DIGITS:0] c;
	assign c[0] = 1'b0;

	for (genvar g = 0; g < DIGITS; g++) begin : g_digit
		logic [4:0] raw;
		assign raw = sub ? ({1'b0, a[4*g+:4]} - {1'b0, b[4*g+:4]} - {4'h0, c[g]})
			: ({1'b0, a[4*g+:4]} + {1'b0, b[4*g+:4]} + {4'h0, c[g]});
		assign c[g+1] = sub ? raw[4] : (raw > 5'd9);
		assign y[4*g+:4] = sub ? (raw[4] ? 4'(raw + 5'd10) : raw[3:0])
			: ((raw > 5'd9) ? 4'(raw - 5'd10) : raw[3:0]);
	end
endmodule // mss_bcd_addsub

// [sim/mss_host.sv]
module mss_host (
	// Clock
	input wire logic sys_clk,
	// Register port
	output logic [11:0] addr,
	output logic [31:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [31:0] rdata,
	// Capture input
	output logic new_master
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		addr = 12'h000;
		wdata = 32'h00000000;
		wr = 1'b0;
		rd = 1'b0;
		new_master = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic write(input logic [11:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
		// Released data flips so nothing stale looks valid
		wdata <= ~d;
	endtask

	task automatic read(input logic [11:0] a, output logic [31:0] d);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	// Level held for a whole count of cycles
	task automatic pin(input int cycles);
		@(posedge sys_clk);
		new_master <= 1'b1;
		repeat (cycles) @(posedge sys_clk);
		new_master <= 1'b0;
	endtask
endmodule // mss_host

// [sim/testbench.sv]
module testbench
	import mss_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic sys_clk = 1'b0;
	logic reset = 1'b1;
	logic dec_valid = 1'b0, dec_good = 1'b0, dec_numeric = 1'b0;
	logic [3:0] dec_len = 4'h0;
	logic [31:0] dec_digits = 32'h00000000;
	logic wr, rd, new_master, res_valid, res_match;
	logic [11:0] addr;
	logic [31:0] wdata, rdata, res_master, rd_val;
	logic [7:0] load_status;
	mss_out_t res_subst;
	int n_mismatch = 0, check_count = 0;
	int master = 0, mlen = 3, step = 1, dir = 0, nr = 1, sm = 0, ms = 0, xs = 0;
	int cap = 0, prev = 0, ld = 0;
	string mtxt = "MATCH";
	string xtxt = "MISMATCH";

	mss_sequencer #(.HOLD_CYC(8)) dut (.SYS_CLK(sys_clk), .RESET(reset), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .NEW_MASTER_IN(new_master),
		.DEC_VALID(dec_valid), .DEC_GOOD(dec_good), .DEC_NUMERIC(dec_numeric),
		.DEC_LEN(dec_len), .DEC_DIGITS(dec_digits), .RES_VALID(res_valid),
		.RES_MATCH(res_match), .RES_SUBST(res_subst), .RES_MASTER(res_master),
		.LOAD_STATUS(load_status));
	mss_host host (.sys_clk(sys_clk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .new_master(new_master));

	initial begin
		forever #25 sys_clk = ~sys_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] bcd(input int v);
		logic [31:0] r;
		for (int i = 0; i < 8; i++) begin
			r[4*i+:4] = 4'(v % 10);
			v = v / 10;
		end
		return r;
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] e);
		host.read(a, rd_val);
		chk(rd_val, e);
	endtask

	task automatic setc;
		host.write(12'h000, 32'(1 + 2*dir + 4*nr + 8*sm + 16*ms + 32*xs + 64*cap));
	endtask

	// Drives one read cycle result and steps the reference model beside it
	task automatic dec(input bit good, input bit num, input int v, input int len);
		bit hit, adv, wasld;
		int mod;
		@(posedge sys_clk);
		dec_valid <= 1'b1;
		dec_good <= good;
		dec_numeric <= num;
		dec_len <= 4'(len);
		dec_digits <= bcd(v);
		@(posedge sys_clk);
		dec_valid <= 1'b0;
		#1;
		hit = 0;
		adv = 0;
		wasld = ld != 0;
		if (wasld) begin
			if (good) begin
				master = v;
				mlen = len;
				prev = 0;
				ld = 0;
			end
		end else if (!good) begin
			adv = nr != 0;
		end else if (num && len == mlen && v == master) begin
			hit = 1;
			adv = 1;
			prev = 1;
		end else begin
			adv = sm != 0 || prev != 0;
			prev = 0;
		end
		mod = 10 ** mlen;
		if (adv)
			master = dir ? (master - step % mod + mod) % mod : (master + step) % mod;
		chk(res_valid, 1);
		chk(res_match, hit);
		chk(res_master, bcd(master));
		chk(load_status, ld);
		chk(res_subst, hit ? ms : ((wasld || !good) ? 0 : 2 * xs));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		int r;
		void'($urandom(48));
		repeat (8) @(posedge sys_clk);
		reset <= 1'b0;
		rchk(12'h000, 32'h4);
		rchk(12'h004, 32'h1);
		rchk(12'h00c, 32'h3);
		rchk(12'h014, 32'h5);
		rchk(12'h018, 32'h8);
		rchk(12'h7fc, 32'h0);
		for (int i = 0; i < 5; i++) rchk(12'h100 + 12'(4*i), 32'(mtxt[i]));
		for (int i = 0; i < 8; i++) rchk(12'h200 + 12'(4*i), 32'(xtxt[i]));
		chk(load_status, 0);
		$display("test reset done");
		// Step of three, then refused step values
		setc;
		host.write(12'h004, 32'h3);
		step = 3;
		host.write(12'h008, 32'h3);
		master = 3;
		for (int v = 1; v <= 6; v++) dec(1, 1, v, 3);
		dec(0, 1, 0, 3);
		rchk(12'h008, bcd(master));
		host.write(12'h004, 32'h0);
		rchk(12'h004, 32'h3);
		host.write(12'h004, 32'h8001);
		rchk(12'h004, 32'h3);
		host.write(12'h004, 32'h8000);
		rchk(12'h004, 32'h8000);
		step = 32768;
		dec(1, 1, master, 3);
		host.write(12'h1fc, 32'h5a);
		rchk(12'h1fc, 32'h5a);
		host.write(12'h014, 32'h40);
		host.write(12'h018, 32'h41);
		rchk(12'h014, 32'h40);
		rchk(12'h018, 32'h8);
		host.write(12'h2fc, 32'h7e);
		rchk(12'h2fc, 32'h7e);
		$display("test step done");
		// Roll-over both ways
		host.write(12'h004, 32'h3);
		step = 3;
		host.write(12'h008, 32'h999);
		master = 999;
		dec(1, 1, 999, 3);
		dir = 1;
		setc;
		dec(1, 1, 2, 3);
		host.write(12'h008, 32'h0);
		master = 0;
		dec(1, 1, 0, 3);
		nr = 0;
		setc;
		dec(0, 1, 0, 3);
		$display("test wrap done");
		// Mismatch stepping and text substitution
		ms = 1;
		xs = 1;
		setc;
		dec(1, 1, master, 3);
		dec(0, 1, 0, 3);
		dec(1, 1, 0, 6);
		dec(1, 1, 0, 6);
		sm = 1;
		setc;
		dec(1, 0, master, 3);
		dec(1, 1, 0, 6);
		$display("test mismatch done");
		// Host load, then capture input
		host.write(12'h010, 32'h1);
		ld = 1;
		rchk(12'h010, 32'h1);
		dec(0, 1, 0, 3);
		dec(1, 1, 4711, 4);
		rchk(12'h00c, 32'h4);
		host.write(12'h00c, 32'h9);
		host.write(12'h00c, 32'h0);
		rchk(12'h00c, 32'h4);
		host.pin(12);
		repeat (3) @(posedge sys_clk);
		#1;
		chk(load_status, 0);
		cap = 1;
		setc;
		host.pin(4);
		repeat (3) @(posedge sys_clk);
		#1;
		chk(load_status, 0);
		host.pin(12);
		repeat (3) @(posedge sys_clk);
		#1;
		ld = 1;
		chk(load_status, 1);
		dec(1, 1, 56789, 5);
		$display("test load done");
		// Random traffic against the model
		for (int i = 0; i < 40; i++) begin
			step = $urandom_range(32768, 1);
			dir = $urandom_range(1);
			nr = $urandom_range(1);
			sm = $urandom_range(1);
			ms = $urandom_range(1);
			xs = $urandom_range(1);
			setc;
			host.write(12'h004, 32'(step));
			r = $urandom_range(3);
			dec(r != 0, r != 1, (r == 3) ? master : $urandom_range(99999), 5);
		end
		$display("test random done");
		conclude;
	end

	// Whole run needs a few hundred cycles
	initial begin
		#1ms;
		n_mismatch++;
		conclude;
	end
endmodule // testbench
